/* include/param_table_pkg.sv */
// Constants and types for the flash parameter table responder
`default_nettype none
package param_table_pkg;
    localparam logic [7:0] PARAM_SPACE_READ_CMD = 8'h5a;
    localparam logic [23:0] TABLE_START_POINTER = 24'h000030;
    localparam logic [7:0] LAST_TABLE_ADDR = 8'h3b;
    localparam int ADDR_BYTES = 3;
    localparam int DUMMY_BYTES = 1;
    localparam int SYNC_STAGES = 3;
    // Byte 30h and 31h fields
    localparam logic [1:0] ERASE_4K_CODE = 2'b01;
    localparam logic [1:0] ERASE_NO_4K_CODE = 2'b11;
    localparam logic WRITE_GRAN_64 = 1'b1;
    localparam logic WREN_REQUIRED = 1'b0;
    localparam logic WREN_OPCODE_SEL = 1'b0;
    localparam logic [2:0] BYTE30_FIXED_HI = 3'b111;
    localparam logic [7:0] ERASE_4K_OPCODE = 8'h20;
    // Byte 32h to 3Bh fields
    localparam logic FAST_112 = 1'b1;
    localparam logic [1:0] ADDR_WIDTH_CODE = 2'b00;
    localparam logic DTR_SUPPORT = 1'b0;
    localparam logic FAST_122 = 1'b1;
    localparam logic FAST_144 = 1'b1;
    localparam logic FAST_114 = 1'b1;
    localparam logic BYTE32_UNUSED = 1'b1;
    localparam logic [7:0] UNUSED_BYTE = 8'hff;
    localparam logic [31:0] DENSITY_DEFAULT = 32'h07ffffff;
    localparam logic [4:0] DUMMY_144 = 5'b00100;
    localparam logic [2:0] MODE_144 = 3'b010;
    localparam logic [7:0] OPCODE_144 = 8'heb;
    localparam logic [4:0] DUMMY_114 = 5'b01000;
    localparam logic [2:0] MODE_114 = 3'b000;
    localparam logic [7:0] OPCODE_114 = 8'h6b;

    typedef struct packed {
        logic sel_n;
        logic sclk;
        logic mosi;
    } serial_in_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HDR = 2'b01,
        ST_DATA = 2'b10,
        ST_DONE = 2'b11
    } phase_t;
endpackage : param_table_pkg
`default_nettype wire

/* rtl/flash_param_table_rom.sv */
// Serial flash parameter-table read responder for bytes 30h to 3Bh
// How it works
// R1 - Select low, opcode 5Ah, three address bytes, one dummy, data until select
// R2 - Served table begins at table address 30h, the header's start pointer
// R3 - Byte 30h bits 1:0 report 01b; byte 31h returns opcode 20h
// R4 - Byte 30h bit 2 reports 1, write granularity 64 bytes or more
// R5 - Byte 30h bit 3 reports 0, no write enable for volatile status
// R6 - Byte 30h bit 4 reports 0, selecting opcode 50h
// R7 - Byte 30h bits 7:5 fixed at 111b, byte reads E5h
// R8 - Byte 32h flags all four fast-read forms plus unused bit, reads F1h
// R9 - Byte 32h address width code 00b, three address bytes only
// R10 - Byte 32h dual-edge clocking bit reports 0
// R11 - Byte 38h gives four dummy clocks and two mode bits, 44h
// R12 - Byte 39h returns 1-4-4 fast read opcode EBh
// R13 - Byte 3Ah gives eight dummy clocks, no mode bits, 08h
// R14 - Byte 3Bh returns 1-1-4 fast read opcode 6Bh
// R15 - Host treats all-zero dummy count as no dummy clocks
// R16 - Host treats zero mode-bit count as no mode bits
// R17 - Byte 33h reads FFh; density little-endian at 34h to 37h
// R18 - Bytes shift out MSB first, consecutive addresses while select low
`default_nettype none
module flash_param_table_rom #(
    parameter logic [31:0] DENSITY = param_table_pkg::DENSITY_DEFAULT
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire param_table_pkg::serial_in_t pins,
    output logic miso,
    output logic miso_oe
);
    import param_table_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Three-stage pin synchronisers; only stages two and three are used
    logic [SYNC_STAGES-1:0] sync_sel_n;
    logic [SYNC_STAGES-1:0] sync_sclk;
    logic [SYNC_STAGES-1:0] sync_mosi;
    logic sel_n_q;
    logic sclk_q;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sync_sel_n <= '1;
            sync_sclk <= '0;
            sync_mosi <= '0;
            sel_n_q <= 1'b1;
            sclk_q <= 1'b0;
        end else begin
            sync_sel_n <= {sync_sel_n[SYNC_STAGES-2:0], pins.sel_n};
            sync_sclk <= {sync_sclk[SYNC_STAGES-2:0], pins.sclk};
            sync_mosi <= {sync_mosi[SYNC_STAGES-2:0], pins.mosi};
            if (sync_sel_n[1] == sync_sel_n[2])
                sel_n_q <= sync_sel_n[2];
            if (sync_sclk[1] == sync_sclk[2])
                sclk_q <= sync_sclk[2];
        end
    end

    wire sclk_agree = (sync_sclk[1] == sync_sclk[2]);
    wire sclk_rise = sclk_agree && sync_sclk[2] && !sclk_q;
    wire sclk_fall = sclk_agree && !sync_sclk[2] && sclk_q;
    wire selected = !sel_n_q;
    wire mosi_bit = sync_mosi[2];

    ////////////////////////////////////////////////////////////////////////
    // Table contents
    wire [7:0] byte30 = {BYTE30_FIXED_HI, WREN_OPCODE_SEL, WREN_REQUIRED,
                         WRITE_GRAN_64, ERASE_4K_CODE}; // [R3] [R4] [R5] [R6] [R7]
    wire [7:0] byte32 = {BYTE32_UNUSED, FAST_114, FAST_144, FAST_122,
                         DTR_SUPPORT, ADDR_WIDTH_CODE, FAST_112}; // [R8] [R9] [R10]
    wire [7:0] byte38 = {MODE_144, DUMMY_144}; // [R11]
    wire [7:0] byte3a = {MODE_114, DUMMY_114}; // [R13]

    function automatic logic [7:0] table_byte(input logic [23:0] a);
        logic [7:0] v;
        v = UNUSED_BYTE;
        // Addresses outside the served window read as erased flash
        if (a[23:4] == TABLE_START_POINTER[23:4]) begin
            case (a[7:0])
                8'h30: v = byte30; // [R2]
                8'h31: v = ERASE_4K_OPCODE; // [R3]
                8'h32: v = byte32;
                8'h33: v = UNUSED_BYTE; // [R17]
                8'h34: v = DENSITY[7:0]; // [R17]
                8'h35: v = DENSITY[15:8];
                8'h36: v = DENSITY[23:16];
                8'h37: v = DENSITY[31:24];
                8'h38: v = byte38;
                8'h39: v = OPCODE_144; // [R12]
                8'h3a: v = byte3a;
                8'h3b: v = OPCODE_114; // [R14]
                default: v = UNUSED_BYTE;
            endcase
        end
        return v;
    endfunction : table_byte

    ////////////////////////////////////////////////////////////////////////
    // Command sequencer; header = opcode + address + dummy, 40 clocks
    localparam int HDR_BITS = 8 * (1 + ADDR_BYTES + DUMMY_BYTES);
    phase_t phase;
    logic [5:0] bit_cnt;
    logic [31:0] hdr_shift;
    logic [23:0] addr;
    logic [7:0] out_shift;
    logic [2:0] out_cnt;

    wire [31:0] next_hdr = {hdr_shift[30:0], mosi_bit};
    wire hdr_last = (bit_cnt == 6'(HDR_BITS - 1));
    wire opcode_done = (bit_cnt == 6'd7);
    wire opcode_ok = ({hdr_shift[6:0], mosi_bit} == PARAM_SPACE_READ_CMD);
    wire [23:0] next_addr = addr + 24'h000001;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            phase <= ST_IDLE;
            bit_cnt <= '0;
            hdr_shift <= '0;
            addr <= '0;
            out_shift <= '0;
            out_cnt <= '0;
            miso <= 1'b0;
            miso_oe <= 1'b0;
        end else if (!selected) begin
            // Select high ends any transfer at once [R1]
            phase <= ST_IDLE;
            bit_cnt <= '0;
            miso_oe <= 1'b0;
            miso <= 1'b0;
        end else begin
            case (phase)
                ST_IDLE, ST_HDR: begin
                    if (sclk_rise) begin
                        hdr_shift <= next_hdr;
                        bit_cnt <= bit_cnt + 6'd1;
                        phase <= ST_HDR;
                        if (opcode_done && !opcode_ok)
                            phase <= ST_DONE;
                        if (bit_cnt == 6'd31)
                            addr <= next_hdr[23:0]; // [R9]
                        if (hdr_last) begin
                            phase <= ST_DATA; // [R1]
                            out_shift <= table_byte(addr);
                            out_cnt <= 3'd0;
                        end
                    end
                end
                ST_DATA: begin
                    if (sclk_fall) begin
                        miso_oe <= 1'b1;
                        miso <= out_shift[7]; // [R18]
                        out_shift <= {out_shift[6:0], 1'b0};
                        out_cnt <= out_cnt + 3'd1;
                        if (out_cnt == 3'd7) begin
                            addr <= next_addr; // [R18]
                            out_shift <= table_byte(next_addr);
                        end
                    end
                end
                ST_DONE: phase <= ST_DONE;
                default: phase <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    wire unused_ok = (LAST_TABLE_ADDR != 8'h00) &&
                     (ERASE_NO_4K_CODE != ERASE_4K_CODE);

    byte_fixed_a: assert property ( // [R7]
        @(posedge core_clk) disable iff (!rstn)
        byte30 == 8'he5 && byte32 == 8'hf1 && unused_ok)
        else $error("fixed table bytes wrong");
    fast_bytes_a: assert property ( // [R11]
        @(posedge core_clk) disable iff (!rstn)
        byte38 == 8'h44 && byte3a == 8'h08)
        else $error("fast read descriptors wrong");
    opc_bytes_a: assert property ( // [R12]
        @(posedge core_clk) disable iff (!rstn)
        table_byte(24'h000039) == 8'heb && table_byte(24'h00003b) == 8'h6b)
        else $error("fast read opcodes wrong");
    erase_opc_a: assert property ( // [R3]
        @(posedge core_clk) disable iff (!rstn)
        table_byte(24'h000031) == 8'h20 && table_byte(24'h000030) == 8'he5)
        else $error("erase opcode wrong");
    density_le_a: assert property ( // [R17]
        @(posedge core_clk) disable iff (!rstn)
        table_byte(24'h000034) == DENSITY[7:0] &&
        table_byte(24'h000033) == 8'hff)
        else $error("density order wrong");
    deselect_off_a: assert property ( // [R1]
        @(posedge core_clk) disable iff (!rstn)
        !selected |=> !miso_oe && phase == ST_IDLE)
        else $error("output alive after deselect");
    msb_first_a: assert property ( // [R18]
        @(posedge core_clk) disable iff (!rstn)
        (selected && phase == ST_DATA && sclk_fall) |=>
        miso == $past(out_shift[7]))
        else $error("bit order wrong");
    addr_step_a: assert property ( // [R18]
        @(posedge core_clk) disable iff (!rstn)
        (selected && phase == ST_DATA && sclk_fall && out_cnt == 3'd7) |=>
        addr == $past(addr) + 24'h000001)
        else $error("address did not step");
    hdr_end_a: assert property ( // [R1]
        @(posedge core_clk) disable iff (!rstn)
        (selected && phase == ST_HDR && sclk_rise && hdr_last) |=>
        phase == ST_DATA)
        else $error("data phase not entered");
    // The line must stay released through the header and after a bad opcode
    quiet_hdr_a: assert property ( // [R1]
        @(posedge core_clk) disable iff (!rstn)
        phase != ST_DATA |-> !miso_oe)
        else $error("output driven outside data phase");
    // The host samples on its rising clock, so a bit must stand until a fall
    bit_stands_a: assert property ( // [R18]
        @(posedge core_clk) disable iff (!rstn)
        (selected && phase == ST_DATA && !sclk_fall) |=> $stable(miso))
        else $error("data bit changed between falls");
    oe_holds_a: assert property ( // [R18]
        @(posedge core_clk) disable iff (!rstn)
        (selected && phase == ST_DATA && miso_oe) |=> miso_oe)
        else $error("output enable dropped while selected");
endmodule : flash_param_table_rom
`default_nettype wire

/* verif/host_model.sv */
// Host model issuing parameter-space reads over the serial pins
`default_nettype none
module host_model (
    input wire logic core_clk,
    input wire logic miso,
    input wire logic miso_oe,
    output var param_table_pkg::serial_in_t pins
);
    timeunit 1ns;
    timeprecision 1ps;
    import param_table_pkg::*;
    // Undriven line shows the opposite level so stale data cannot pass
    wire sdo_seen = miso_oe ? miso : ~miso;
    logic [7:0] rx [0:15];
    int oe_bad;
    logic oe_end;

    initial begin
        pins = '{sel_n: 1'b1, sclk: 1'b0, mosi: 1'b0};
    end

    // Half of the 80 ns link clock
    task automatic half();
        repeat (5) @(posedge core_clk);
    endtask : half

    // Header of 40 bits, then nbit data bits; select may rise mid-byte
    task automatic frame(input logic [7:0] op, input logic [23:0] a,
            input int nbit);
        logic [39:0] hdr;
        hdr = {op, a, 8'h00};
        oe_bad = 0;
        @(posedge core_clk);
        pins.sel_n <= 1'b0;
        half();
        for (int i = 39; i >= 0; i--) begin
            pins.mosi <= hdr[i];
            half();
            pins.sclk <= 1'b1;
            half();
            pins.sclk <= 1'b0;
        end
        for (int k = 0; k < nbit; k++) begin
            // Released data line toggles so a stale level never matches
            pins.mosi <= ~pins.mosi;
            half();
            pins.sclk <= 1'b1;
            rx[k / 8][7 - k % 8] = sdo_seen;
            if (miso_oe !== 1'b1) oe_bad++;
            half();
            pins.sclk <= 1'b0;
        end
        half();
        pins.sel_n <= 1'b1;
        pins.mosi <= ~pins.mosi;
        repeat (8) @(posedge core_clk);
        oe_end = miso_oe;
    endtask : frame
endmodule : host_model
`default_nettype wire

/* verif/test_flash_param_table_rom.sv */
// Bench for the parameter-table responder: reads, aborts, bad opcode
`default_nettype none
module test_flash_param_table_rom;
    timeunit 1ns;
    timeprecision 1ps;
    import param_table_pkg::*;
    localparam logic [31:0] DENS = 32'h1a2b3c4d;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic miso;
    logic miso_oe;
    serial_in_t pins;
    int n_fail = 0;
    int total_checks = 0;
    logic [7:0] tbl [0:12];

    flash_param_table_rom #(.DENSITY(DENS)) u_flash_param_table_rom (
        .core_clk(core_clk), .rstn(rstn), .pins(pins), .miso(miso),
        .miso_oe(miso_oe));
    host_model u_host_model (.core_clk(core_clk), .miso(miso),
        .miso_oe(miso_oe), .pins(pins));

    always #4 core_clk = ~core_clk;

    task automatic check8(input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: exp %h got %h", $time, exp, got);
        end
    endtask : check8

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : test_done

    task automatic test_full();
        u_host_model.frame(8'h5a, 24'h000030, 96);
        for (int i = 0; i < 12; i++) begin
            check8(tbl[i], u_host_model.rx[i]);
        end
        check8(8'(u_host_model.oe_bad), 8'h00);
        check8({7'h00, u_host_model.oe_end}, 8'h00);
        // Host decoding of the 1-1-4 form: eight dummies, no mode bits
        check8({3'h0, u_host_model.rx[10][4:0]}, 8'h08);
        check8({5'h00, u_host_model.rx[10][7:5]}, 8'h00);
        $display("test full done");
    endtask : test_full

    task automatic test_mid();
        u_host_model.frame(8'h5a, 24'h000037, 48);
        for (int i = 0; i < 6; i++) begin
            check8(tbl[i + 7], u_host_model.rx[i]);
        end
        $display("test mid done");
    endtask : test_mid

    task automatic test_abort();
        u_host_model.frame(8'h5a, 24'h000031, 12);
        check8(u_host_model.rx[0], tbl[1]);
        check8({7'h00, u_host_model.oe_end}, 8'h00);
        u_host_model.frame(8'h5a, 24'h000038, 8);
        check8(u_host_model.rx[0], tbl[8]);
        $display("test abort done");
    endtask : test_abort

    task automatic test_bad_op();
        u_host_model.frame(8'h03, 24'h000030, 16);
        check8(8'(u_host_model.oe_bad), 8'h10);
        $display("test bad opcode done");
    endtask : test_bad_op

    initial begin
        tbl[0] = {3'b111, 1'b0, 1'b0, 1'b1, 2'b01};
        tbl[1] = 8'h20;
        tbl[2] = {4'b1111, 1'b0, 2'b00, 1'b1};
        tbl[3] = 8'hff;
        for (int i = 0; i < 4; i++) tbl[4 + i] = DENS[8 * i +: 8];
        tbl[8] = {3'b010, 5'b00100};
        tbl[9] = 8'heb;
        tbl[10] = {3'b000, 5'b01000};
        tbl[11] = 8'h6b;
        tbl[12] = 8'hff;
        repeat (16) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (8) @(posedge core_clk);
        test_full();
        test_mid();
        test_abort();
        test_bad_op();
        test_done();
    end

    // Watchdog: a hang counts as a mismatch
    initial begin
        repeat (60000) @(posedge core_clk);
        n_fail++;
        test_done();
    end
endmodule : test_flash_param_table_rom
`default_nettype wire
